// >>> design/ihcp_pkg.sv
package ihcp_pkg;
    // Link addresses and command bytes
    localparam logic [7:0] ADDR_WR    = 8'h44;
    localparam logic [7:0] ADDR_RD    = 8'h45;
    localparam logic [3:0] CMD_TX_LOW = 4'h4;
    localparam logic [7:0] CMD_FEND   = 8'h0F;
    localparam logic [7:0] CMD_WREG   = 8'hF5;
    localparam logic [7:0] CMD_RREG   = 8'hFD;
    localparam logic [7:0] CMD_RINT   = 8'h01;
    localparam logic [7:0] CMD_RERR   = 8'h11;
    localparam logic [7:0] DUMMY_BYTE = 8'hFF;
    localparam logic [1:0] IF_SEL_I2C = 2'h3;
    // Error status byte bit positions
    localparam int ERR_RX_OVF = 1;
    localparam int ERR_TX_OVF = 2;
    localparam int ERR_ILLEGAL = 3;
    // Status byte bit positions
    localparam int ST_FEND  = 2;
    localparam int ST_EMPTY = 4;
    localparam int ST_EOF   = 5;
    localparam int ST_ERR   = 7;
    // Carrier channel register
    localparam logic [7:0] REG_CHAN         = 8'h10;
    localparam int         CARRIER_RESET_KHZ = 13000;
    localparam int         CARRIER_BASE_KHZ  = 5000;
    localparam int         CARRIER_STEP_KHZ  = 100;
    localparam logic [7:0] CHAN_RESET =
        8'((CARRIER_RESET_KHZ - CARRIER_BASE_KHZ) / CARRIER_STEP_KHZ);
    // Host register map
    localparam logic [11:0] HOST_CMD_OFF  = 12'h000;
    localparam logic [11:0] HOST_STAT_OFF = 12'h004;
    localparam int HC_OP_LSB  = 8;
    localparam int HC_READ    = 10;
    localparam int HC_NACK    = 11;
    localparam int HC_AUTO    = 12;
    localparam int HS_BUSY    = 0;
    localparam int HS_ACK     = 1;
    localparam int HS_ATT     = 2;
    localparam int HS_RX_LSB  = 8;
    // Serial clock timing
    localparam int PCLK_KHZ = 40000;
    localparam int SCL_KHZ  = 400;
    localparam int QTR_CYC  = PCLK_KHZ / (SCL_KHZ * 4);

    typedef enum logic [1:0] {
        IHCP_OP_NONE  = 2'b00,
        IHCP_OP_START = 2'b01,
        IHCP_OP_STOP  = 2'b10,
        IHCP_OP_BYTE  = 2'b11
    } ihcp_op_t;
endpackage : ihcp_pkg

// >>> design/ihcp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface ihcp_if;
    logic scl;
    logic host_sda_o;
    logic host_sda_oe;
    logic serial_data_line;
    logic dev_sda_o;
    logic dev_sda_oe;
    logic attention;
    // Open drain with pull-up: any enabled low driver wins
    assign serial_data_line = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
    modport dev  (input scl, input serial_data_line, output dev_sda_o, output dev_sda_oe, output attention);
    modport host (output scl, output host_sda_o, output host_sda_oe, input serial_data_line, input attention);
endinterface : ihcp_if
`default_nettype wire

// >>> design/ihcp_device.sv
`timescale 1ns/100ps
`default_nettype none
module ihcp_device (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Interface select strap
    input  wire logic [1:0] if_sel,
    // Serial link
    ihcp_if.dev             link,
    // Receive queue head
    input  wire logic       rx_empty,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_last,
    output logic            rx_pop,
    // Queue events
    input  wire logic       rx_frame_end,
    input  wire logic       rx_overflow,
    input  wire logic       tx_overflow,
    // Transmit frame
    output logic            tx_open,
    output logic [1:0]      tx_codec,
    output logic            tx_valid,
    output logic [7:0]      tx_data,
    output logic            tx_close,
    // Control registers
    output logic            reg_wr,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata,
    output logic [7:0]      carrier_chan,
    output logic            i2c_mode
);
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_RX   = 3'b001,
        PH_RACK = 3'b010,
        PH_TX   = 3'b011,
        PH_TACK = 3'b100
    } ihcp_ph_t;

    typedef enum logic [1:0] {
        SRC_DRAIN = 2'b00,
        SRC_REG   = 2'b01,
        SRC_INT   = 2'b10,
        SRC_ERR   = 2'b11
    } ihcp_src_t;

    typedef struct packed {
        logic [1:0] sel1;
        logic [1:0] sel2;
        logic       mode;
        logic       scl1;
        logic       scl2;
        logic       scl3;
        logic       sda1;
        logic       sda2;
        logic       sda3;
        ihcp_ph_t   ph;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic       rd;
        logic [1:0] bidx;
        logic [7:0] cmd;
        ihcp_src_t  src;
        logic       oe;
        logic       att;
        logic [3:1] err;
        logic       fend;
        logic       eof;
        logic [7:0] chan;
        logic       pop;
        logic       open;
        logic [1:0] codec;
        logic       txv;
        logic [7:0] txd;
        logic       close;
        logic       wr;
        logic [7:0] ra;
        logic [7:0] wd;
    } ihcp_dev_t;

    ihcp_dev_t r;
    ihcp_dev_t n;

    function automatic logic ihcp_is_tx(input logic [7:0] c);
        return (c[3:0] == ihcp_pkg::CMD_TX_LOW) && (c[7:6] == 2'h0);
    endfunction : ihcp_is_tx

    logic       rise;
    logic       fall;
    logic       start;
    logic       stop;
    logic       clr_int;
    logic       clr_err;
    logic [7:0] status;
    logic [7:0] errbyte;
    logic [7:0] txbyte;

    always_comb begin
        rise  = r.scl2 && !r.scl3;
        fall  = !r.scl2 && r.scl3;
        start = r.mode && r.scl2 && r.scl3 && r.sda3 && !r.sda2;
        stop  = r.mode && r.scl2 && r.scl3 && !r.sda3 && r.sda2;
        status = 8'h00;
        status[ihcp_pkg::ST_FEND]  = r.fend;
        status[ihcp_pkg::ST_EMPTY] = rx_empty;
        status[ihcp_pkg::ST_EOF]   = r.eof;
        status[ihcp_pkg::ST_ERR]   = |r.err;
        errbyte = {4'h0, r.err, 1'b0};
        unique case (r.src)
            SRC_DRAIN: txbyte = rx_empty ? ihcp_pkg::DUMMY_BYTE : rx_data;
            SRC_REG:   txbyte = (r.ra == ihcp_pkg::REG_CHAN) ? r.chan : reg_rdata;
            SRC_INT:   txbyte = status;
            SRC_ERR:   txbyte = errbyte;
        endcase
    end

    always_comb begin
        n = r;
        n.sel1  = if_sel;
        n.sel2  = r.sel1;
        n.mode  = (r.sel2 == ihcp_pkg::IF_SEL_I2C);
        n.scl1  = link.scl;
        n.scl2  = r.scl1;
        n.scl3  = r.scl2;
        n.sda1  = link.serial_data_line;
        n.sda2  = r.sda1;
        n.sda3  = r.sda2;
        n.pop   = 1'b0;
        n.open  = 1'b0;
        n.txv   = 1'b0;
        n.close = 1'b0;
        n.wr    = 1'b0;
        clr_int = 1'b0;
        clr_err = 1'b0;
        if (!r.mode) begin
            n.ph = PH_IDLE;
            n.oe = 1'b0;
        end else if (start) begin
            n.ph   = PH_RX;
            n.bitn = 4'h0;
            n.bidx = 2'h0;
            n.oe   = 1'b0;
        end else if (stop) begin
            n.ph  = PH_IDLE;
            n.oe  = 1'b0;
            n.src = SRC_DRAIN;
        end else begin
            unique case (r.ph)
                PH_IDLE: n.oe = 1'b0;
                PH_RX: begin
                    if (rise && r.bitn != 4'h8) begin
                        n.sh   = {r.sh[6:0], r.sda2};
                        n.bitn = r.bitn + 4'h1;
                    end else if (fall && r.bitn == 4'h8) begin
                        n.ph = PH_RACK;
                        n.oe = 1'b1;
                        if (r.bidx == 2'h0) begin
                            if (r.sh == ihcp_pkg::ADDR_WR) begin
                                n.rd = 1'b0;
                            end else if (r.sh == ihcp_pkg::ADDR_RD) begin
                                n.rd = 1'b1;
                            end else begin
                                n.ph = PH_IDLE;
                                n.oe = 1'b0;
                            end
                        end else if (r.bidx == 2'h1) begin
                            n.cmd = r.sh;
                            if (ihcp_is_tx(r.sh)) begin
                                n.open  = 1'b1;
                                n.codec = r.sh[5:4];
                            end else if (r.sh == ihcp_pkg::CMD_FEND) begin
                                n.close = 1'b1;
                            end else if (r.sh == ihcp_pkg::CMD_RINT) begin
                                n.src = SRC_INT;
                            end else if (r.sh == ihcp_pkg::CMD_RERR) begin
                                n.src = SRC_ERR;
                            end else if (r.sh != ihcp_pkg::CMD_WREG && r.sh != ihcp_pkg::CMD_RREG) begin
                                n.err[ihcp_pkg::ERR_ILLEGAL] = 1'b1;
                            end
                        end else if (ihcp_is_tx(r.cmd)) begin
                            n.txv = 1'b1;
                            n.txd = r.sh;
                        end else if (r.bidx == 2'h2 && r.cmd == ihcp_pkg::CMD_RREG) begin
                            n.ra  = r.sh;
                            n.src = SRC_REG;
                        end else if (r.bidx == 2'h2 && r.cmd == ihcp_pkg::CMD_WREG) begin
                            n.ra = r.sh;
                        end else if (r.bidx == 2'h3 && r.cmd == ihcp_pkg::CMD_WREG) begin
                            n.wd = r.sh;
                            n.wr = 1'b1;
                            if (r.ra == ihcp_pkg::REG_CHAN) begin
                                n.chan = r.sh;
                            end
                        end else begin
                            n.err[ihcp_pkg::ERR_ILLEGAL] = 1'b1;
                        end
                    end
                end
                PH_RACK: begin
                    if (fall) begin
                        n.oe = 1'b0;
                        if (r.rd) begin
                            n.ph   = PH_TX;
                            n.bitn = 4'h1;
                            n.sh   = txbyte;
                            n.oe   = !txbyte[7];
                            if (r.src == SRC_DRAIN && !rx_empty) begin
                                n.pop = 1'b1;
                            end
                        end else begin
                            n.ph   = PH_RX;
                            n.bitn = 4'h0;
                            if (r.bidx != 2'h3) begin
                                n.bidx = r.bidx + 2'h1;
                            end
                        end
                    end
                end
                PH_TX: begin
                    if (fall) begin
                        if (r.bitn == 4'h8) begin
                            n.oe = 1'b0;
                            n.ph = PH_TACK;
                        end else begin
                            n.sh   = {r.sh[6:0], 1'b0};
                            n.oe   = !r.sh[6];
                            n.bitn = r.bitn + 4'h1;
                        end
                    end
                end
                PH_TACK: begin
                    if (rise) begin
                        clr_int = (r.src == SRC_INT);
                        clr_err = (r.src == SRC_ERR);
                        if (r.src != SRC_DRAIN) begin
                            n.src = SRC_DRAIN;
                        end
                        // A NACK ends the read until the next START; a STOP leaves it idle
                        n.ph = r.sda2 ? PH_IDLE : PH_RACK;
                    end
                end
                default: n.ph = PH_IDLE;
            endcase
        end
        // Hardware set wins over a fetch clear in the same cycle
        n.fend = (r.fend && !clr_int) || rx_frame_end;
        n.eof  = (r.eof && !clr_int) || (n.pop && rx_last);
        n.err[ihcp_pkg::ERR_RX_OVF] = (n.err[ihcp_pkg::ERR_RX_OVF] && !clr_err) || rx_overflow;
        n.err[ihcp_pkg::ERR_TX_OVF] = (n.err[ihcp_pkg::ERR_TX_OVF] && !clr_err) || tx_overflow;
        if (clr_err && !(start || stop) && r.ph == PH_TACK) begin
            n.err[ihcp_pkg::ERR_ILLEGAL] = 1'b0;
        end
        n.att = n.fend || n.eof || (|n.err);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r      <= '0;
            r.scl1 <= 1'b1;
            r.scl2 <= 1'b1;
            r.scl3 <= 1'b1;
            r.sda1 <= 1'b1;
            r.sda2 <= 1'b1;
            r.sda3 <= 1'b1;
            r.chan <= ihcp_pkg::CHAN_RESET;
        end else begin
            r <= n;
        end
    end

    assign link.dev_sda_o  = 1'b0;
    assign link.dev_sda_oe = r.oe;
    assign link.attention  = r.att;
    assign rx_pop          = r.pop;
    assign tx_open         = r.open;
    assign tx_codec        = r.codec;
    assign tx_valid        = r.txv;
    assign tx_data         = r.txd;
    assign tx_close        = r.close;
    assign reg_wr          = r.wr;
    assign reg_addr        = r.ra;
    assign reg_wdata       = r.wd;
    assign carrier_chan    = r.chan;
    assign i2c_mode        = r.mode;
endmodule : ihcp_device
`default_nettype wire

// >>> design/ihcp_host.sv
`timescale 1ns/100ps
`default_nettype none
module ihcp_host #(
    parameter int QTR_CYC = ihcp_pkg::QTR_CYC
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial link
    ihcp_if.host             link
);
    if (QTR_CYC < 2 || QTR_CYC > 255) begin : g_bad_qtr
        $error("QTR_CYC must lie in 2..255");
    end

    typedef struct packed {
        logic             sda1;
        logic             sda2;
        logic             att1;
        logic             att2;
        ihcp_pkg::ihcp_op_t op;
        logic [1:0]       q;
        logic [7:0]       cnt;
        logic [3:0]       bitn;
        logic [7:0]       sh;
        logic             rd;
        logic             nack;
        logic             auto_ack;
        logic             scl;
        logic             oe;
        logic             ack;
        logic [7:0]       rxb;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
    } ihcp_host_t;

    ihcp_host_t r;
    ihcp_host_t n;
    logic       tick;
    logic       hit;

    always_comb begin
        n       = r;
        n.sda1  = link.serial_data_line;
        n.sda2  = r.sda1;
        n.att1  = link.attention;
        n.att2  = r.att1;
        tick    = (r.op != ihcp_pkg::IHCP_OP_NONE) && (r.cnt == 8'h00);
        hit     = (paddr == ihcp_pkg::HOST_CMD_OFF) || (paddr == ihcp_pkg::HOST_STAT_OFF);
        // One wait state: pready rises in the second access cycle
        n.pready  = psel && penable && !r.pready;
        n.pslverr = psel && penable && !r.pready && !hit;
        n.prdata  = 32'h0000_0000;
        if (psel && penable && !r.pready && !pwrite && paddr == ihcp_pkg::HOST_STAT_OFF) begin
            n.prdata[ihcp_pkg::HS_BUSY] = (r.op != ihcp_pkg::IHCP_OP_NONE);
            n.prdata[ihcp_pkg::HS_ACK]  = r.ack;
            n.prdata[ihcp_pkg::HS_ATT]  = r.att2;
            n.prdata[ihcp_pkg::HS_RX_LSB +: 8] = r.rxb;
        end
        if (r.op != ihcp_pkg::IHCP_OP_NONE) begin
            n.cnt = tick ? 8'(QTR_CYC - 1) : r.cnt - 8'h01;
        end
        if (tick) begin
            n.q = r.q + 2'h1;
            unique case (r.op)
                ihcp_pkg::IHCP_OP_START: begin
                    unique case (r.q)
                        2'h0: n.oe  = 1'b0;
                        2'h1: n.scl = 1'b1;
                        2'h2: n.oe  = 1'b1;
                        2'h3: begin
                            n.scl = 1'b0;
                            n.op  = ihcp_pkg::IHCP_OP_NONE;
                        end
                    endcase
                end
                ihcp_pkg::IHCP_OP_STOP: begin
                    unique case (r.q)
                        2'h0: n.oe  = 1'b1;
                        2'h1: n.scl = 1'b1;
                        2'h2: n.oe  = 1'b0;
                        2'h3: n.op  = ihcp_pkg::IHCP_OP_NONE;
                    endcase
                end
                default: begin
                    unique case (r.q)
                        2'h0: begin
                            if (r.bitn != 4'h8) begin
                                n.oe = !r.rd && !r.sh[7];
                            end else begin
                                // Auto mode ACKs only while attention is low
                                n.oe = r.rd && !(r.auto_ack ? r.att2 : r.nack);
                            end
                        end
                        2'h1: n.scl = 1'b1;
                        2'h2: begin
                            if (r.bitn != 4'h8) begin
                                n.sh = {r.sh[6:0], r.sda2};
                            end else begin
                                n.ack = !r.sda2;
                            end
                        end
                        2'h3: begin
                            n.scl  = 1'b0;
                            n.bitn = r.bitn + 4'h1;
                            if (r.bitn == 4'h8) begin
                                n.oe  = 1'b0;
                                n.rxb = r.sh;
                                n.op  = ihcp_pkg::IHCP_OP_NONE;
                            end
                        end
                    endcase
                end
            endcase
        end
        // Commands written while busy are dropped
        if (psel && penable && r.pready && pwrite && paddr == ihcp_pkg::HOST_CMD_OFF
            && r.op == ihcp_pkg::IHCP_OP_NONE) begin
            n.op       = ihcp_pkg::ihcp_op_t'(pwdata[ihcp_pkg::HC_OP_LSB +: 2]);
            n.sh       = pwdata[7:0];
            n.rd       = pwdata[ihcp_pkg::HC_READ];
            n.nack     = pwdata[ihcp_pkg::HC_NACK];
            n.auto_ack = pwdata[ihcp_pkg::HC_AUTO];
            n.q        = 2'h0;
            n.bitn     = 4'h0;
            n.cnt      = 8'(QTR_CYC - 1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r      <= '0;
            r.sda1 <= 1'b1;
            r.sda2 <= 1'b1;
            r.scl  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign link.scl         = r.scl;
    assign link.host_sda_o  = 1'b0;
    assign link.host_sda_oe = r.oe;
    assign prdata           = r.prdata;
    assign pready           = r.pready;
    assign pslverr          = r.pslverr;
endmodule : ihcp_host
`default_nettype wire

// >>> tb/ihcp_sva.sv
`timescale 1ns/100ps
`default_nettype none
module ihcp_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Link
    input wire logic scl,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic serial_data_line,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic attention
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence scl_hi; scl [*4]; endsequence
    sequence scl_lo; !scl [*4]; endsequence
    sequence dev_held; $stable(dev_sda_oe) [*4]; endsequence
    AST_SCL_HIGH: assert property ($rose(scl) |-> scl_hi)
        else $error("Clock high phase short");
    AST_SCL_LOW: assert property ($fell(scl) |-> scl_lo)
        else $error("Clock low phase short");
    AST_DEV_HOLD: assert property ($rose(scl) |-> dev_held)
        else $error("Device pin moved in high phase");
    AST_DEV_LOW_ONLY: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("Device pin moved with clock high");
    AST_HOST_OD: assert property (host_sda_oe |-> !host_sda_o)
        else $error("Host drives data high");
    AST_DEV_OD: assert property (dev_sda_oe |-> !dev_sda_o && !serial_data_line)
        else $error("Device pull not seen on line");
    AST_NO_FIGHT: assert property (dev_sda_oe && scl |-> !host_sda_oe)
        else $error("Both ends pull in high phase");
    AST_ATT_FALL: assert property ($fell(attention) |-> scl && $past(scl, 1))
        else $error("Attention fell outside ninth clock");
    AST_SCL_IDLE: assert property ($rose(presetn) |-> scl)
        else $error("Clock not idle high");
endmodule : ihcp_sva
`default_nettype wire

// >>> tb/i2c_host_command_port_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_host_command_port_tb_top;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        rx_pop, rx_frame_end, rx_overflow, tx_overflow, tx_open, tx_valid, tx_close, reg_wr;
    logic        rx_empty, rx_last, i2c_mode, closed, opened;
    logic [7:0]  wdat;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, st;
    logic [1:0]  tx_codec, idx;
    logic [7:0]  tx_data, reg_addr, reg_wdata, reg_rdata, carrier_chan, txd, rx_data;
    int          failures, checks_done;
    assign rx_empty = (idx == 2'd2);
    assign rx_last = (idx == 2'd1);
    assign rx_data = idx[0] ? 8'hC3 : 8'h5A;
    assign reg_rdata = reg_addr ^ 8'h5A;
    // Queue and frame sinks keep one driver each and clear during reset
    always @(posedge pclk) begin
        if (!presetn) begin
            {idx, closed, opened, txd, wdat} <= '0;
        end else begin
            if (rx_pop) idx <= idx + 2'd1;
            if (tx_valid) txd <= tx_data;
            if (tx_close) closed <= 1'b1;
            if (tx_open) opened <= 1'b1;
            if (reg_wr) wdat <= reg_wdata;
        end
    end
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    ihcp_if i_ihcp_if ();
    ihcp_device i_ihcp_device (.pclk(pclk), .presetn(presetn), .if_sel(2'b11), .link(i_ihcp_if),
        .rx_empty(rx_empty), .rx_data(rx_data), .rx_last(rx_last), .rx_pop(rx_pop), .rx_frame_end(rx_frame_end),
        .rx_overflow(rx_overflow), .tx_overflow(tx_overflow), .tx_open(tx_open), .tx_codec(tx_codec),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_close(tx_close), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .carrier_chan(carrier_chan), .i2c_mode(i2c_mode));
    ihcp_host #(.QTR_CYC(4)) i_ihcp_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(i_ihcp_if));
    ihcp_sva i_ihcp_sva (.pclk(pclk), .presetn(presetn), .scl(i_ihcp_if.scl), .host_sda_o(i_ihcp_if.host_sda_o),
        .host_sda_oe(i_ihcp_if.host_sda_oe), .serial_data_line(i_ihcp_if.serial_data_line),
        .dev_sda_o(i_ihcp_if.dev_sda_o), .dev_sda_oe(i_ihcp_if.dev_sda_oe), .attention(i_ihcp_if.attention));
    task automatic final_report();
        if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        st = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Busy poll is bounded; a host that never idles ends the run as a failure
    task automatic lk(input logic [1:0] op, input logic [7:0] d, input logic rd, input logic nk);
        int n;
        n = 0;
        apb(1'b1, ihcp_pkg::HOST_CMD_OFF, {19'h0_0000, rd & !nk, nk, rd, op, d});
        do begin
            apb(1'b0, ihcp_pkg::HOST_STAT_OFF, 32'h0000_0000);
            n++;
        end while (st[0] !== 1'b0 && n < 500);
        if (st[0] !== 1'b0) begin
            failures++;
            final_report();
        end
    endtask : lk
    task automatic wb(input logic [7:0] d);
        lk(2'd3, d, 1'b0, 1'b0);
        chk(8'(st[1]), 8'h01);
    endtask : wb
    task automatic go(input logic [7:0] cmd);
        lk(2'd1, 8'h00, 1'b0, 1'b0);
        wb(ihcp_pkg::ADDR_WR);
        wb(cmd);
    endtask : go
    task automatic rd_phase(input logic [7:0] e);
        lk(2'd1, 8'h00, 1'b0, 1'b0);
        wb(ihcp_pkg::ADDR_RD);
        lk(2'd3, 8'h00, 1'b1, 1'b1);
        chk(st[15:8], e);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
    endtask : rd_phase
    task automatic wait_att(input logic v);
        int n;
        for (n = 0; n < 100 && i_ihcp_if.attention !== v; n++) @(posedge pclk);
        chk(8'(i_ihcp_if.attention), 8'(v));
    endtask : wait_att
    task automatic t_regs();
        chk(carrier_chan, ihcp_pkg::CHAN_RESET);
        chk(8'(i2c_mode), 8'h01);
        go(ihcp_pkg::CMD_WREG);
        wb(ihcp_pkg::REG_CHAN);
        wb(8'h2A);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
        chk(carrier_chan, 8'h2A);
        chk(wdat, 8'h2A);
        go(ihcp_pkg::CMD_RREG);
        wb(ihcp_pkg::REG_CHAN);
        rd_phase(8'h2A);
        go(ihcp_pkg::CMD_RREG);
        wb(8'h01);
        rd_phase(8'h5B);
        lk(2'd1, 8'h00, 1'b0, 1'b0);
        lk(2'd3, 8'h52, 1'b0, 1'b0);
        chk(8'(st[1]), 8'h00);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
        apb(1'b0, 12'hFF0, 32'h0000_0000);
        chk(8'(err), 8'h01);
    endtask : t_regs
    task automatic t_frame();
        go(8'h34);
        wb(8'hA5);
        chk(8'(tx_codec), 8'h03);
        chk(txd, 8'hA5);
        chk(8'(opened), 8'h01);
        go(ihcp_pkg::CMD_FEND);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
        chk(8'(closed), 8'h01);
    endtask : t_frame
    task automatic t_rx();
        @(posedge pclk);
        rx_frame_end <= 1'b1;
        @(posedge pclk);
        rx_frame_end <= 1'b0;
        wait_att(1'b1);
        go(ihcp_pkg::CMD_RINT);
        rd_phase(8'h04);
        wait_att(1'b0);
        lk(2'd1, 8'h00, 1'b0, 1'b0);
        wb(ihcp_pkg::ADDR_RD);
        lk(2'd3, 8'h00, 1'b1, 1'b0);
        chk(st[15:8], 8'h5A);
        chk(8'(st[1]), 8'h01);
        lk(2'd3, 8'h00, 1'b1, 1'b0);
        chk(st[15:8], 8'hC3);
        chk(8'(st[1]), 8'h00);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
        go(ihcp_pkg::CMD_RINT);
        rd_phase(8'h30);
        rd_phase(ihcp_pkg::DUMMY_BYTE);
    endtask : t_rx
    task automatic t_err();
        @(posedge pclk);
        rx_overflow <= 1'b1;
        tx_overflow <= 1'b1;
        @(posedge pclk);
        rx_overflow <= 1'b0;
        tx_overflow <= 1'b0;
        go(8'h77);
        lk(2'd2, 8'h00, 1'b0, 1'b0);
        wait_att(1'b1);
        go(ihcp_pkg::CMD_RINT);
        rd_phase(8'h90);
        repeat (20) @(posedge pclk);
        chk(8'(i_ihcp_if.attention), 8'h01);
        go(ihcp_pkg::CMD_RERR);
        rd_phase(8'h0E);
        wait_att(1'b0);
        go(ihcp_pkg::CMD_RERR);
        rd_phase(8'h00);
    endtask : t_err
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rx_frame_end, rx_overflow, tx_overflow} = '0;
        {failures, checks_done} = '0;
        presetn = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (8) @(posedge pclk);
        t_regs();
        t_frame();
        t_rx();
        t_err();
        final_report();
    end
    initial begin
        repeat (60000) @(posedge pclk);
        failures++;
        final_report();
    end
endmodule : i2c_host_command_port_tb_top
`default_nettype wire
